// ===== trig_eval_pkg.sv
// Package: sizes, encodings, carriers and helpers of the trigger evaluator.
package trig_eval_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_SIG = 8;
    localparam int BUS_W   = 16;
    localparam int ADDR_W  = 32;
    localparam int BUF_AW  = 7;
    localparam int SHAMT_W = 4;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [BUF_AW-1:0] WADDR_RESET     = 7'h00;
    localparam logic [BUF_AW-1:0] POST_LAST       = 7'h01;
    // Samples stored after the trigger sample, per position setting.
    localparam logic [BUF_AW-1:0] POST_LEN_EARLY  = 7'h70;
    localparam logic [BUF_AW-1:0] POST_LEN_CENTER = 7'h40;
    localparam logic [BUF_AW-1:0] POST_LEN_LATE   = 7'h10;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_DONT_CARE = 3'h0,
        PAT_LOW       = 3'h1,
        PAT_HIGH      = 3'h2,
        PAT_FALL      = 3'h3,
        PAT_RISE      = 3'h4,
        PAT_EITHER    = 3'h5
    } pat_t;

    typedef enum logic [2:0] {
        CMP_LT = 3'h0, CMP_LE = 3'h1, CMP_EQ = 3'h2,
        CMP_NE = 3'h3, CMP_GT = 3'h4, CMP_GE = 3'h5
    } cmp_op_t;

    typedef enum logic [1:0] {
        BIT_AND = 2'h0, BIT_OR = 2'h1, BIT_XOR = 2'h2, BIT_INV = 2'h3
    } bit_op_t;

    typedef enum logic [1:0] {SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2} shift_dir_t;
    typedef enum logic [1:0] {RED_AND = 2'h0, RED_OR = 2'h1, RED_XOR = 2'h2} red_op_t;
    typedef enum logic [1:0] {LOG_AND = 2'h0, LOG_OR = 2'h1, LOG_XOR = 2'h2} log_op_t;
    typedef enum logic [1:0] {POS_EARLY = 2'h0, POS_CENTER = 2'h1, POS_LATE = 2'h2} position_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE  = 4'h2,
        ST_POST = 4'h4,
        ST_DONE = 4'h8
    } state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SIG-1:0] sig;
        logic [BUS_W-1:0]   bus_a;
        logic [BUS_W-1:0]   bus_b;
        logic [ADDR_W-1:0]  iaddr;
    } probe_t;

    typedef struct packed {
        logic [NUM_SIG-1:0][2:0] pat;
        logic [BUS_W-1:0]        bus_value;
        logic [BUS_W-1:0]        bus_care;
        logic                    addr_en;
        logic [ADDR_W-1:0]       addr_target;
    } basic_cfg_t;

    typedef struct packed {
        cmp_op_t            cmp_op;
        bit_op_t            bit_op;
        shift_dir_t         shift_dir;
        logic [SHAMT_W-1:0] shamt;
        red_op_t            red_op;
        logic [2:0]         det_sel;
        pat_t               det_mode;
        logic [2:0]         term_en;
        logic [2:0]         term_inv;
        log_op_t            log_op;
    } adv_cfg_t;

    // True when one signal matches its pattern; edges need a valid previous sample.
    function automatic logic pat_match(logic [2:0] pat, logic cur, logic prev, logic pv);
        logic rise;
        logic fall;
        rise = pv & ~prev & cur;
        fall = pv & prev & ~cur;
        case (pat)
            PAT_DONT_CARE: pat_match = 1'b1;
            PAT_LOW:       pat_match = ~cur;
            PAT_HIGH:      pat_match = cur;
            PAT_FALL:      pat_match = fall;
            PAT_RISE:      pat_match = rise;
            PAT_EITHER:    pat_match = rise | fall;
            default:       pat_match = 1'b0;
        endcase
    endfunction : pat_match

    // Number of samples kept after the trigger sample.
    function automatic logic [BUF_AW-1:0] post_len(position_t pos);
        case (pos)
            POS_EARLY:  post_len = POST_LEN_EARLY;
            POS_CENTER: post_len = POST_LEN_CENTER;
            default:    post_len = POST_LEN_LATE;
        endcase
    endfunction : post_len

endpackage : trig_eval_pkg

// ===== adv_expr_eval.sv
// Module: combinational expression tree of the advanced trigger mode.
`timescale 1ns/1ns
module adv_expr_eval (
    // Current and previous samples.
    input  trig_eval_pkg::probe_t   cur,
    input  trig_eval_pkg::probe_t   prev,
    input  wire logic               prev_valid,
    // Operator settings, live at every cycle.
    input  trig_eval_pkg::adv_cfg_t cfg,
    // Result of the tree.
    output logic                    expr_true
);

    logic                             cmp_true;
    logic                             red_true;
    logic                             det_true;
    logic [trig_eval_pkg::BUS_W-1:0]  bitw;
    logic [trig_eval_pkg::BUS_W-1:0]  shifted;
    logic [2:0]                       term;

    // ------------------------------------------------------------
    // Leaf operators
    // ------------------------------------------------------------
    // Settings are read straight from the inputs, so a new operator takes effect on the same sample.
    always_comb begin
        case (cfg.cmp_op)
            trig_eval_pkg::CMP_LT: cmp_true = cur.bus_a <  cur.bus_b;
            trig_eval_pkg::CMP_LE: cmp_true = cur.bus_a <= cur.bus_b;
            trig_eval_pkg::CMP_EQ: cmp_true = cur.bus_a == cur.bus_b;
            trig_eval_pkg::CMP_NE: cmp_true = cur.bus_a != cur.bus_b;
            trig_eval_pkg::CMP_GT: cmp_true = cur.bus_a >  cur.bus_b;
            trig_eval_pkg::CMP_GE: cmp_true = cur.bus_a >= cur.bus_b;
            default:               cmp_true = 1'b0;
        endcase
        case (cfg.bit_op)
            trig_eval_pkg::BIT_AND: bitw = cur.bus_a & cur.bus_b;
            trig_eval_pkg::BIT_OR:  bitw = cur.bus_a | cur.bus_b;
            trig_eval_pkg::BIT_XOR: bitw = cur.bus_a ^ cur.bus_b;
            default:                bitw = ~cur.bus_a;
        endcase
        case (cfg.shift_dir)
            trig_eval_pkg::SH_LEFT:  shifted = bitw << cfg.shamt;
            trig_eval_pkg::SH_RIGHT: shifted = bitw >> cfg.shamt;
            default:                 shifted = bitw;
        endcase
        // All-ones reduction lets a bitwise result fire only when every bit is set.
        case (cfg.red_op)
            trig_eval_pkg::RED_AND: red_true = &shifted;
            trig_eval_pkg::RED_OR:  red_true = |shifted;
            trig_eval_pkg::RED_XOR: red_true = ^shifted;
            default:                red_true = 1'b0;
        endcase
        det_true = trig_eval_pkg::pat_match(cfg.det_mode, cur.sig[cfg.det_sel],
                                            prev.sig[cfg.det_sel], prev_valid);
    end

    // ------------------------------------------------------------
    // Root logical operator
    // ------------------------------------------------------------
    // Disabled terms take the neutral value of the root operator.
    always_comb begin
        term = {det_true, red_true, cmp_true} ^ cfg.term_inv;
        case (cfg.log_op)
            trig_eval_pkg::LOG_OR:  expr_true = |(term & cfg.term_en);
            trig_eval_pkg::LOG_XOR: expr_true = ^(term & cfg.term_en);
            default:                expr_true = &(term | ~cfg.term_en);
        endcase
    end

endmodule : adv_expr_eval

// ===== trig_evaluator.sv
// Module: trigger evaluation and capture control of the on-chip logic analyzer.
//
// Contract
// - Each monitored signal matches its own pattern: don't care, low, high, fall, rise, either.
// - In basic mode the bus is compared bit by bit against a value under a care mask.
// - A basic condition holds only when every per-signal match holds, then the trigger fires and post-trigger capture starts.
// - In basic mode with the address check on, the trigger fires only when the address equals the target.
// - In advanced mode an operator tree computes the condition that decides the trigger.
// - The tree compares buses by less, less-equal, equal, unequal, greater, greater-equal.
// - The tree offers logical, reduction, shift and bitwise operators.
// - A detector operator reports a level or an edge of one selected signal.
// - Operator settings and types may change while running, with no rebuild.
// - A reduction on a bitwise result can fire when all of its bits are one.
// - After the trigger, samples are stored until the buffer fills for the chosen position.
`timescale 1ns/1ns
module trig_evaluator (
    // Clock and reset.
    input  wire logic                              clk,
    input  wire logic                              resetn,
    // Sampled signals of the monitored design.
    input  trig_eval_pkg::probe_t                  sample,
    // Trigger settings.
    input  wire logic                              advanced,
    input  trig_eval_pkg::position_t               position,
    input  trig_eval_pkg::basic_cfg_t              basic_cfg,
    input  trig_eval_pkg::adv_cfg_t                adv_cfg,
    // Run control.
    input  wire logic                              arm,
    input  wire logic                              abort,
    // Capture buffer write port.
    output logic                                   capture_we,
    output logic [trig_eval_pkg::BUF_AW-1:0]       capture_addr,
    output trig_eval_pkg::probe_t                  capture_data,
    // Trigger status.
    output logic [trig_eval_pkg::BUF_AW-1:0]       trigger_addr,
    output logic                                   triggered,
    output logic                                   trigger_pulse,
    output logic                                   acq_done
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    trig_eval_pkg::state_t                 state;
    trig_eval_pkg::state_t                 next_state;
    trig_eval_pkg::probe_t                 prev_sample;
    trig_eval_pkg::probe_t                 next_prev_sample;
    logic                                  prev_valid;
    logic                                  next_prev_valid;
    logic [trig_eval_pkg::BUF_AW-1:0]      waddr;
    logic [trig_eval_pkg::BUF_AW-1:0]      next_waddr;
    logic [trig_eval_pkg::BUF_AW-1:0]      post_left;
    logic [trig_eval_pkg::BUF_AW-1:0]      next_post_left;
    logic [trig_eval_pkg::BUF_AW-1:0]      next_trigger_addr;
    logic [trig_eval_pkg::BUF_AW-1:0]      next_capture_addr;
    trig_eval_pkg::probe_t                 next_capture_data;
    logic                                  next_capture_we;
    logic                                  next_triggered;
    logic                                  next_trigger_pulse;
    logic                                  next_acq_done;
    logic [trig_eval_pkg::NUM_SIG-1:0]     sig_match;
    logic                                  bus_match;
    logic                                  addr_match;
    logic                                  basic_true;
    logic                                  adv_true;
    logic                                  cond;

    // ------------------------------------------------------------
    // Previous sample
    // ------------------------------------------------------------
    // Edges are undefined until one sample has been seen, so the valid flag gates them.
    always_comb begin
        next_prev_sample = sample;
        next_prev_valid  = 1'b1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_sample <= '0;
            prev_valid  <= 1'b0;
        end else begin
            prev_sample <= next_prev_sample;
            prev_valid  <= next_prev_valid;
        end
    end

    // ------------------------------------------------------------
    // Basic condition
    // ------------------------------------------------------------
    // Every signal, the masked bus and the address, when its check is on, must agree at once.
    always_comb begin
        for (int i = 0; i < trig_eval_pkg::NUM_SIG; i++) begin
            sig_match[i] = trig_eval_pkg::pat_match(basic_cfg.pat[i], sample.sig[i],
                                                    prev_sample.sig[i], prev_valid);
        end
        bus_match  = ~|((sample.bus_a ^ basic_cfg.bus_value) & basic_cfg.bus_care);
        addr_match = ~basic_cfg.addr_en | (sample.iaddr == basic_cfg.addr_target);
        basic_true = (&sig_match) & bus_match & addr_match;
    end

    // ------------------------------------------------------------
    // Advanced condition
    // ------------------------------------------------------------
    adv_expr_eval u_adv_expr_eval (
        .cur        (sample),
        .prev       (prev_sample),
        .prev_valid (prev_valid),
        .cfg        (adv_cfg),
        .expr_true  (adv_true)
    );

    // Mode switch is live, so the tree can be swapped in while armed.
    always_comb begin
        cond = advanced ? adv_true : basic_true;
    end

    // ------------------------------------------------------------
    // Capture control
    // ------------------------------------------------------------
    // The trigger sample and the post-trigger samples are written; the buffer
    // wraps before the trigger, so the oldest data is overwritten.
    always_comb begin
        next_state         = state;
        next_waddr         = waddr;
        next_post_left     = post_left;
        next_trigger_addr  = trigger_addr;
        next_triggered     = triggered;
        next_trigger_pulse = 1'b0;
        next_capture_we    = 1'b0;
        next_capture_addr  = capture_addr;
        next_capture_data  = capture_data;
        next_acq_done      = acq_done;
        unique case (state)
            trig_eval_pkg::ST_IDLE, trig_eval_pkg::ST_DONE: begin
                if (arm) begin
                    next_state     = trig_eval_pkg::ST_PRE;
                    next_waddr     = trig_eval_pkg::WADDR_RESET;
                    next_triggered = 1'b0;
                    next_acq_done  = 1'b0;
                end
            end
            trig_eval_pkg::ST_PRE: begin
                next_capture_we   = 1'b1;
                next_capture_addr = waddr;
                next_capture_data = sample;
                next_waddr        = waddr + 7'h01;
                if (cond) begin
                    next_state         = trig_eval_pkg::ST_POST;
                    next_trigger_addr  = waddr;
                    next_post_left     = trig_eval_pkg::post_len(position);
                    next_triggered     = 1'b1;
                    next_trigger_pulse = 1'b1;
                end
            end
            trig_eval_pkg::ST_POST: begin
                next_capture_we   = 1'b1;
                next_capture_addr = waddr;
                next_capture_data = sample;
                next_waddr        = waddr + 7'h01;
                next_post_left    = post_left - 7'h01;
                if (post_left == trig_eval_pkg::POST_LAST) begin
                    next_state    = trig_eval_pkg::ST_DONE;
                    next_acq_done = 1'b1;
                end
            end
            default: begin
                next_state = trig_eval_pkg::ST_IDLE;
            end
        endcase
        // Abort wins over the state, write, pulse, triggered and done updates so software can always regain control.
        if (abort) begin
            next_state         = trig_eval_pkg::ST_IDLE;
            next_capture_we    = 1'b0;
            next_trigger_pulse = 1'b0;
            next_triggered     = triggered;
            next_acq_done      = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state         <= trig_eval_pkg::ST_IDLE;
            waddr         <= trig_eval_pkg::WADDR_RESET;
            post_left     <= trig_eval_pkg::WADDR_RESET;
            trigger_addr  <= trig_eval_pkg::WADDR_RESET;
            triggered     <= 1'b0;
            trigger_pulse <= 1'b0;
            capture_we    <= 1'b0;
            capture_addr  <= trig_eval_pkg::WADDR_RESET;
            capture_data  <= '0;
            acq_done      <= 1'b0;
        end else begin
            state         <= next_state;
            waddr         <= next_waddr;
            post_left     <= next_post_left;
            trigger_addr  <= next_trigger_addr;
            triggered     <= next_triggered;
            trigger_pulse <= next_trigger_pulse;
            capture_we    <= next_capture_we;
            capture_addr  <= next_capture_addr;
            capture_data  <= next_capture_data;
            acq_done      <= next_acq_done;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Helper: a sample is evaluated this cycle and not overridden by abort.
    logic watch;
    logic watch_basic;
    logic watch_adv;
    assign watch       = (state == trig_eval_pkg::ST_PRE) && !abort;
    assign watch_basic = watch && !advanced;
    assign watch_adv   = watch && advanced && (adv_cfg.term_inv == 3'h0)
                         && (adv_cfg.log_op == trig_eval_pkg::LOG_AND);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_low_pattern: assert property (
        watch_basic && basic_cfg.pat[0] == trig_eval_pkg::PAT_LOW && sample.sig[0]
        |=> !trigger_pulse)
        else $error("low pattern fired on a high signal");

    a_bus_mask: assert property (
        watch_basic && |((sample.bus_a ^ basic_cfg.bus_value) & basic_cfg.bus_care)
        |=> !trigger_pulse)
        else $error("bus pattern mismatch still fired");

    a_all_terms_fire: assert property (
        watch && cond
        |=> trigger_pulse && triggered && capture_we ##1 !trigger_pulse)
        else $error("met condition did not fire once");

    a_addr_target: assert property (
        watch_basic && basic_cfg.addr_en && sample.iaddr != basic_cfg.addr_target
        |=> !trigger_pulse)
        else $error("address trigger fired off target");

    a_adv_tree_gate: assert property (
        watch && advanced && !adv_true |=> !trigger_pulse)
        else $error("advanced mode fired with a false tree");

    a_compare_ge: assert property (
        watch_adv && adv_cfg.term_en == 3'h1 && adv_cfg.cmp_op == trig_eval_pkg::CMP_GE
        && sample.bus_a < sample.bus_b |=> !trigger_pulse)
        else $error("greater-equal compare fired while less");

    a_reduce_all_ones: assert property (
        watch_adv && adv_cfg.term_en == 3'h2 && adv_cfg.bit_op == trig_eval_pkg::BIT_AND
        && adv_cfg.shift_dir == trig_eval_pkg::SH_NONE
        && adv_cfg.red_op == trig_eval_pkg::RED_AND
        && (sample.bus_a & sample.bus_b) == 16'hFFFF |=> trigger_pulse)
        else $error("all-ones bitwise result did not fire");

    a_edge_prev: assert property (
        watch_adv && adv_cfg.term_en == 3'h4 && adv_cfg.det_mode == trig_eval_pkg::PAT_RISE
        && !(prev_valid && !prev_sample.sig[adv_cfg.det_sel] && sample.sig[adv_cfg.det_sel])
        |=> !trigger_pulse)
        else $error("rise detector fired without a rising edge");

    a_post_fill: assert property (
        state == trig_eval_pkg::ST_POST && !abort
        |=> capture_we && capture_addr == $past(waddr))
        else $error("post-trigger sample not stored");

    // The late setting stores sixteen samples after the trigger, the last one raising done.
    a_done_on_full: assert property (
        trigger_pulse && position == trig_eval_pkg::POS_LATE && !abort
        ##1 !abort [*8] ##1 !abort [*7]
        |-> !acq_done ##1 acq_done)
        else $error("late position did not end after its sample count");

    c_basic_trigger: cover property (watch_basic && cond ##1 trigger_pulse);
    c_adv_trigger:   cover property (watch && advanced && cond ##1 trigger_pulse);
    c_done:          cover property ($rose(acq_done));
    c_rearm:         cover property (acq_done && arm ##1 state == trig_eval_pkg::ST_PRE);

endmodule : trig_evaluator

// ===== user_logic_model.sv
// Model of the monitored user logic that feeds the probe.
`timescale 1ns/1ns
module user_logic_model (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            resetn,
    // Wanted values and the sampled probe.
    input  trig_eval_pkg::probe_t want,
    output trig_eval_pkg::probe_t sample
);
    // Launched by a flop, so the probe never moves within a cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample <= '0;
        end else begin
            sample <= want;
        end
    end
endmodule : user_logic_model

// ===== trig_evaluator_tb_top.sv
// Testbench: trigger evaluator fed by a model of the monitored logic.
`timescale 1ns/1ns
module trig_evaluator_tb_top;
    typedef struct packed {
        logic                      adv;
        trig_eval_pkg::basic_cfg_t bc;
        trig_eval_pkg::adv_cfg_t   ac;
        trig_eval_pkg::probe_t     s0;
        trig_eval_pkg::probe_t     s1;
        logic                      exp;
    } row_t;
    logic                             clk = 1'b0;
    logic                             resetn = 1'b0;
    logic                             advanced = 1'b0;
    logic                             arm = 1'b0;
    logic                             abort = 1'b0;
    trig_eval_pkg::position_t         position = trig_eval_pkg::POS_LATE;
    trig_eval_pkg::basic_cfg_t        bc = '0;
    trig_eval_pkg::adv_cfg_t          ac = '0;
    trig_eval_pkg::probe_t            want = '0;
    trig_eval_pkg::probe_t            sample;
    logic                             capture_we, triggered, trigger_pulse, acq_done;
    logic [trig_eval_pkg::BUF_AW-1:0] capture_addr, trigger_addr;
    int                               n_mismatch = 0, checks = 0, cycles = 0, nwe = 0, n0;
    int                               post[3];
    row_t                             rows[$];
    row_t                             r;

    user_logic_model model_u (.clk(clk), .resetn(resetn), .want(want), .sample(sample));
    trig_evaluator dut_u (.clk(clk), .resetn(resetn), .sample(sample), .advanced(advanced),
        .position(position), .basic_cfg(bc), .adv_cfg(ac), .arm(arm), .abort(abort),
        .capture_we(capture_we), .capture_addr(capture_addr), .capture_data(),
        .trigger_addr(trigger_addr), .triggered(triggered), .trigger_pulse(trigger_pulse),
        .acq_done(acq_done));

    // Clock, write counter and hang guard; the count is read only at clock edges.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        nwe <= nwe + int'(capture_we);
        if (cycles == 6000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // Settle s0 one edge before arming so no stray edge is seen, then move to s1.
    task automatic apply(row_t x);
        advanced <= x.adv;
        bc <= x.bc;
        ac <= x.ac;
        want <= x.s0;
        tick(1);
        arm <= 1'b1;
        tick(1);
        arm <= 1'b0;
        tick(1);
        want <= x.s1;
        tick(5);
    endtask : apply

    task automatic stop();
        abort <= 1'b1;
        tick(1);
        abort <= 1'b0;
        tick(1);
    endtask : stop

    initial begin
        post = '{trig_eval_pkg::POST_LEN_EARLY, trig_eval_pkg::POST_LEN_CENTER,
                 trig_eval_pkg::POST_LEN_LATE};
        // Pattern codes 0..6 on a rising then a falling signal.
        for (int i = 0; i < 14; i++) begin
            r = '0;
            r.bc.pat[0] = 3'(i % 7);
            r.s0.sig[0] = (i >= 7);
            r.s1.sig[0] = (i < 7);
            r.exp = 14'h17B7 >> i;
            rows.push_back(r);
        end
        // Every compare op with a above b, then a below b.
        for (int i = 0; i < 12; i++) begin
            r = '0;
            r.adv = 1'b1;
            r.ac.term_en = 3'h1;
            r.ac.cmp_op = trig_eval_pkg::cmp_op_t'(i % 6);
            r.s0.bus_a = (i < 6) ? 16'h0004 : 16'h0003;
            r.s0.bus_b = (i < 6) ? 16'h0003 : 16'h0004;
            r.s1 = r.s0;
            r.exp = 12'h2F8 >> i;
            rows.push_back(r);
        end
        // Masked bus, then target address, each hit and miss.
        r = '0;
        r.bc.bus_care = 16'h00FF;
        r.bc.bus_value = 16'h0012;
        r.s0.bus_a = 16'h1200;
        for (int i = 0; i < 2; i++) begin
            r.s1.bus_a = 16'hCD12 + 16'(i);
            r.exp = (i == 0);
            rows.push_back(r);
        end
        r = '0;
        r.bc.addr_en = 1'b1;
        r.bc.addr_target = 32'h00001F40;
        for (int i = 0; i < 2; i++) begin
            r.s1.iaddr = 32'h00001F40 + 32'(4 * i);
            r.exp = (i == 0);
            rows.push_back(r);
        end
        // All-ones of a bitwise AND, then rise detector, then XOR of compare and detector.
        r = '0;
        r.adv = 1'b1;
        r.ac.term_en = 3'h2;
        r.s0.bus_a = 16'hFFFF;
        r.s0.bus_b = 16'h7FFF;
        r.s1.bus_a = 16'hFFFF;
        r.s1.bus_b = 16'hFFFF;
        r.exp = 1'b1;
        rows.push_back(r);
        r = '0;
        r.adv = 1'b1;
        r.ac.term_en = 3'h4;
        r.ac.det_sel = 3'h3;
        r.ac.det_mode = trig_eval_pkg::PAT_RISE;
        r.s1.sig = 8'h08;
        r.exp = 1'b1;
        rows.push_back(r);
        r.ac.term_en = 3'h5;
        r.ac.log_op = trig_eval_pkg::LOG_XOR;
        r.ac.cmp_op = trig_eval_pkg::CMP_EQ;
        r.ac.det_mode = trig_eval_pkg::PAT_HIGH;
        r.s0.bus_a = 16'h0001;
        r.exp = 1'b0;
        rows.push_back(r);

        tick(10);
        resetn <= 1'b1;
        tick(1);
        check("capture_we", 0, capture_we);
        check("acq_done", 0, acq_done);
        foreach (rows[i]) begin
            apply(rows[i]);
            check("triggered", rows[i].exp, triggered);
            stop();
        end
        // Operator changed while running, without re-arming.
        r = rows[14];
        apply(r);
        check("triggered", 0, triggered);
        ac.cmp_op <= trig_eval_pkg::CMP_GT;
        tick(3);
        check("triggered", 1, triggered);
        stop();
        // Trigger on the first sample; count writes for every position setting.
        for (int p = 0; p < 3; p++) begin
            position <= trig_eval_pkg::position_t'(p);
            n0 = nwe;
            apply('0);
            tick(130);
            check("writes", post[p] + 1, nwe - n0);
            check("acq_done", 1, acq_done);
            check("trigger_addr", 0, trigger_addr);
            check("capture_addr", post[p], capture_addr);
            stop();
        end
        test_done();
    end
endmodule : trig_evaluator_tb_top
